// [rtl/can_sched_params.svh]
`ifndef CAN_SCHED_PARAMS_SVH
`define CAN_SCHED_PARAMS_SVH

// ************************************************************
// Clock and timing
// ************************************************************
`define CLK_PERIOD_NS 10
`define SLICE_TIME_NS 1600000
`define SLICE_CYCLES (`SLICE_TIME_NS / `CLK_PERIOD_NS)
`define PDO_SPACING_NS 4000000
`define PDO_LATENCY_NS 4800000
`define SDO_LATENCY_NS 8000000
`define BIT_TIME_125_NS 8000
`define BIT_TIME_250_NS 4000
`define BIT_TIME_500_NS 2000
`define BIT_CYCLES_125 (`BIT_TIME_125_NS / `CLK_PERIOD_NS)
`define BIT_CYCLES_250 (`BIT_TIME_250_NS / `CLK_PERIOD_NS)
`define BIT_CYCLES_500 (`BIT_TIME_500_NS / `CLK_PERIOD_NS)

// ************************************************************
// Register map
// ************************************************************
`define REG_CONFIG 8'h00
`define REG_STATUS 8'h04
`define REG_DROPS 8'h08
`define CFG_BASE_LSB 0
`define CFG_BASE_MSB 6
`define CFG_ADD_EN 7
`define CFG_RATE_LSB 8
`define CFG_RATE_MSB 9
`define CFG_ACTIVE 10
`define CFG_RESET 11'h001
`define STAT_NODE_MSB 6
`define STAT_SLOT_BUSY 8
`define STAT_PDO_HOLD 9
`define STAT_REPLY_WAIT 10

// ************************************************************
// Message identifiers (function code base values)
// ************************************************************
`define ID_SYNC 11'h080
`define ID_EMCY 11'h080
`define ID_TPDO1 11'h180
`define ID_RPDO1 11'h200
`define ID_TPDO2 11'h280
`define ID_RPDO2 11'h300
`define ID_TSDO 11'h580
`define ID_RSDO 11'h600

`endif

// [rtl/can_sched_pkg.sv]
package can_sched_pkg;
  // One-hot states of the process-data engine
  typedef enum logic [1:0] {
    PDO_IDLE = 2'b01,
    PDO_HOLD = 2'b10
  } pdo_state_t;

  // Bit rate selection codes
  typedef enum logic [1:0] {
    RATE_125 = 2'h0,
    RATE_250 = 2'h1,
    RATE_500 = 2'h2
  } bit_rate_t;

  // Kind held in the single service/special slot
  typedef enum logic {
    SLOT_SDO = 1'b0,
    SLOT_SYNC = 1'b1
  } slot_kind_t;
endpackage : can_sched_pkg

// [rtl/can_message_scheduler.sv]
`timescale 1ns/1ps
`include "can_sched_params.svh"

// Functional notes
// - Start one interpreter slice every 1.6 ms from a free-running timer.
// - Each slice handles at most one service-data or special message.
// - A complex process-data message occupies two consecutive slices.
// - Process-data takes effect within 4.8 ms of being sent.
// - Service-data reply leaves within 8 ms of the request.
// - Bus bit rate selectable among 125, 250 and 500 kbit/s.
// - With addition enabled, node number is base plus four jumper inputs.
// - Jumpers are sampled only after reset or on interface activation.
// - Message identifiers other than sync are derived from the effective node number.
// - Interface-active bit gates reception, bit ticks and replies at once; already queued process data and sync still go out.
// - Exactly two process-data receive channels exist.
module can_message_scheduler import can_sched_pkg::*; #(
  parameter int SLICE_CYCLES = `SLICE_CYCLES,
  parameter int DATA_W = 32,
  parameter int PDO_CHANNELS = 2
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rd_data_out,
  input wire logic [3:0] node_offset_jumper_inputs_in,
  input wire logic rx_valid_in,
  input wire logic [10:0] rx_id_in,
  input wire logic [DATA_W-1:0] rx_data_in,
  input wire logic rx_complex_in,
  output logic bus_enable_out,
  output logic bit_tick_out,
  output logic slice_tick_out,
  output logic pdo_valid_out,
  output logic pdo_channel_out,
  output logic [DATA_W-1:0] pdo_data_out,
  output logic sdo_reply_valid_out,
  output logic [10:0] sdo_reply_id_out,
  output logic [DATA_W-1:0] sdo_reply_data_out,
  output logic sync_out,
  output logic [10:0] tpdo1_id_out,
  output logic [10:0] tpdo2_id_out,
  output logic [10:0] emcy_id_out
);

  // ************************************************************
  // Configuration and status registers
  // ************************************************************
  logic [10:0] config_reg;
  logic [15:0] drop_count;
  logic [6:0] eff_node;
  logic [3:0] jumper_latch;
  logic capture_pending;
  logic active_d;

  // Field views of the configuration
  wire [6:0] base_node = config_reg[`CFG_BASE_MSB:`CFG_BASE_LSB];
  wire add_en = config_reg[`CFG_ADD_EN];
  wire [1:0] rate_sel = config_reg[`CFG_RATE_MSB:`CFG_RATE_LSB];
  wire active = config_reg[`CFG_ACTIVE];
  wire sel_config = addr_in == `REG_CONFIG;
  wire sel_status = addr_in == `REG_STATUS;
  wire sel_drops = addr_in == `REG_DROPS;

  // Configuration write; takes effect on the next cycle, no reset needed
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      config_reg <= `CFG_RESET;
    end else if (wr_in && sel_config) begin
      config_reg <= wr_data_in[10:0];
    end
  end

  // ************************************************************
  // Node number capture
  // ************************************************************
  // Capture is requested at reset and on each rising edge of the active bit
  wire activate_edge = active && !active_d;

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      active_d <= 1'b0;
      capture_pending <= 1'b1;
      jumper_latch <= 4'h0;
    end else begin
      active_d <= active;
      capture_pending <= 1'b0;
      if (capture_pending || activate_edge) begin
        jumper_latch <= node_offset_jumper_inputs_in;
      end
    end
  end

  // Effective node; base changes apply at once, jumpers only via the latch
  wire [6:0] jumper_add = add_en ? {3'h0, jumper_latch} : 7'h00;
  wire [6:0] next_eff_node = 7'(base_node + jumper_add);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      eff_node <= 7'h00;
    end else begin
      eff_node <= next_eff_node;
    end
  end

  // Identifiers for this node
  wire [10:0] node_ext = {4'h0, eff_node};
  wire [10:0] id_rpdo1 = 11'(`ID_RPDO1 + node_ext);
  wire [10:0] id_rpdo2 = 11'(`ID_RPDO2 + node_ext);
  wire [10:0] id_rsdo = 11'(`ID_RSDO + node_ext);

  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      tpdo1_id_out <= `ID_TPDO1;
      tpdo2_id_out <= `ID_TPDO2;
      emcy_id_out <= `ID_EMCY;
      bus_enable_out <= 1'b0;
    end else begin
      tpdo1_id_out <= 11'(`ID_TPDO1 + node_ext);
      tpdo2_id_out <= 11'(`ID_TPDO2 + node_ext);
      emcy_id_out <= 11'(`ID_EMCY + node_ext);
      bus_enable_out <= active;
    end
  end

  // ************************************************************
  // Bit rate and slice timers
  // ************************************************************
  logic [15:0] bit_count;
  logic [31:0] slice_count;

  // Unused code 3 falls back to the slowest rate
  wire [15:0] bit_limit = (rate_sel == RATE_500) ? 16'(`BIT_CYCLES_500 - 1) :
                          (rate_sel == RATE_250) ? 16'(`BIT_CYCLES_250 - 1) :
                          16'(`BIT_CYCLES_125 - 1);
  wire bit_wrap = bit_count >= bit_limit;
  wire slice_wrap = slice_count == 32'(SLICE_CYCLES - 1);

  // Slice timer runs free so the period never depends on message load
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      bit_count <= 16'h0000;
      slice_count <= 32'h0000_0000;
      bit_tick_out <= 1'b0;
      slice_tick_out <= 1'b0;
    end else begin
      bit_count <= bit_wrap ? 16'h0000 : 16'(bit_count + 16'h0001);
      bit_tick_out <= bit_wrap && active;
      slice_count <= slice_wrap ? 32'h0000_0000 : 32'(slice_count + 32'h0000_0001);
      slice_tick_out <= slice_wrap;
    end
  end

  // ************************************************************
  // Receive acceptance
  // ************************************************************
  // Nothing is accepted while the interface is inactive
  wire rx_ok = rx_valid_in && active;
  wire hit_pdo1 = rx_ok && rx_id_in == id_rpdo1;
  wire hit_pdo2 = rx_ok && rx_id_in == id_rpdo2;
  wire hit_sdo = rx_ok && rx_id_in == id_rsdo;
  wire hit_sync = rx_ok && rx_id_in == `ID_SYNC;
  wire hit_slot = hit_sdo || hit_sync;

  // Per-channel process-data holding cells; a newer message overwrites
  logic [PDO_CHANNELS-1:0] pdo_pend;
  logic [PDO_CHANNELS-1:0] pdo_cplx;
  logic [DATA_W-1:0] pdo_buf [PDO_CHANNELS];

  // Single service/special slot
  logic slot_busy;
  slot_kind_t slot_kind;
  logic [DATA_W-1:0] slot_data;

  // Engine state
  pdo_state_t pdo_state;
  logic hold_chan;
  logic reply_wait;
  logic [DATA_W-1:0] reply_data;

  // Engine picks channel 0 first; it cannot take a new one while holding
  wire tick = slice_wrap;
  wire take_pdo = tick && pdo_state == PDO_IDLE && (pdo_pend != 2'b00);
  wire take_chan = !pdo_pend[0];
  wire take_slot = tick && slot_busy;
  wire [PDO_CHANNELS-1:0] hit_pdo = {hit_pdo2, hit_pdo1};
  wire [PDO_CHANNELS-1:0] take_mask = take_pdo ? (take_chan ? 2'b10 : 2'b01) : 2'b00;

  // Losses: overwritten process data or a full slot
  wire pdo_lost = |(hit_pdo & pdo_pend & ~take_mask);
  wire slot_lost = hit_slot && slot_busy && !take_slot;

  // ************************************************************
  // Process-data cells
  // ************************************************************
  genvar ch;
  generate
    for (ch = 0; ch < PDO_CHANNELS; ch++) begin : g_pdo
      // Arrival wins over the take in the same cycle
      always_ff @(posedge clock_in) begin
        if (rst_in) begin
          pdo_pend[ch] <= 1'b0;
          pdo_cplx[ch] <= 1'b0;
          pdo_buf[ch] <= '0;
        end else if (hit_pdo[ch]) begin
          pdo_pend[ch] <= 1'b1;
          pdo_cplx[ch] <= rx_complex_in;
          pdo_buf[ch] <= rx_data_in;
        end else if (take_mask[ch]) begin
          pdo_pend[ch] <= 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Process-data engine
  // ************************************************************
  wire [DATA_W-1:0] take_data = take_chan ? pdo_buf[1] : pdo_buf[0];
  wire take_cplx = take_chan ? pdo_cplx[1] : pdo_cplx[0];
  logic [DATA_W-1:0] hold_data;

  // A simple message applies in its first slice, a complex one in the next
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      pdo_state <= PDO_IDLE;
      hold_chan <= 1'b0;
      hold_data <= '0;
      pdo_valid_out <= 1'b0;
      pdo_channel_out <= 1'b0;
      pdo_data_out <= '0;
    end else begin
      pdo_valid_out <= 1'b0;
      unique case (pdo_state)
        PDO_IDLE: begin
          if (take_pdo && take_cplx) begin
            pdo_state <= PDO_HOLD;
            hold_chan <= take_chan;
            hold_data <= take_data;
          end else if (take_pdo) begin
            pdo_valid_out <= 1'b1;
            pdo_channel_out <= take_chan;
            pdo_data_out <= take_data;
          end
        end
        PDO_HOLD: begin
          if (tick) begin
            pdo_state <= PDO_IDLE;
            pdo_valid_out <= 1'b1;
            pdo_channel_out <= hold_chan;
            pdo_data_out <= hold_data;
          end
        end
      endcase
    end
  end

  // ************************************************************
  // Service and special slot
  // ************************************************************
  // Arrival in the taking cycle refills the slot, so nothing is lost
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      slot_busy <= 1'b0;
      slot_kind <= SLOT_SDO;
      slot_data <= '0;
    end else if (hit_slot && (!slot_busy || take_slot)) begin
      slot_busy <= 1'b1;
      slot_kind <= hit_sync ? SLOT_SYNC : SLOT_SDO;
      slot_data <= rx_data_in;
    end else if (take_slot) begin
      slot_busy <= 1'b0;
    end
  end

  // Reply is compiled during one slice and sent at the following tick
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      reply_wait <= 1'b0;
      reply_data <= '0;
      sync_out <= 1'b0;
      sdo_reply_valid_out <= 1'b0;
      sdo_reply_id_out <= `ID_TSDO;
      sdo_reply_data_out <= '0;
    end else begin
      sync_out <= take_slot && slot_kind == SLOT_SYNC;
      sdo_reply_valid_out <= tick && reply_wait && active;
      if (tick && reply_wait) begin
        sdo_reply_id_out <= 11'(`ID_TSDO + node_ext);
        sdo_reply_data_out <= reply_data;
      end
      if (take_slot && slot_kind == SLOT_SDO) begin
        reply_wait <= 1'b1;
        reply_data <= slot_data;
      end else if (tick) begin
        reply_wait <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Loss counter and read port
  // ************************************************************
  wire any_lost = pdo_lost || slot_lost;

  // Saturating so software sees a stuck maximum rather than a wrap
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      drop_count <= 16'h0000;
    end else if (wr_in && sel_drops) begin
      drop_count <= 16'h0000;
    end else if (any_lost && drop_count != 16'hFFFF) begin
      drop_count <= 16'(drop_count + 16'h0001);
    end
  end

  // Status word: node, slot, engine and reply flags
  wire [31:0] status_word = {21'h0, reply_wait, pdo_state == PDO_HOLD, slot_busy,
                             1'b0, eff_node};
  wire [31:0] next_rd_data = sel_config ? {21'h0, config_reg} :
                             sel_status ? status_word :
                             sel_drops ? {16'h0000, drop_count} : 32'h0000_0000;

  // Read data stand one cycle after the strobe only
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      rd_data_out <= 32'h0000_0000;
    end else begin
      rd_data_out <= rd_in ? next_rd_data : 32'h0000_0000;
    end
  end

endmodule : can_message_scheduler

// [tb/can_sched_checker.sv]
`timescale 1ns/1ps
// ************************************************************
// Scheduler port checker
// ************************************************************
module can_sched_checker import can_sched_pkg::*; #(
  parameter int SLICE_CYCLES = 20
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic rd_in,
  input wire logic [31:0] rd_data_out,
  input wire logic rx_valid_in,
  input wire logic [10:0] rx_id_in,
  input wire logic bus_enable_out,
  input wire logic bit_tick_out,
  input wire logic slice_tick_out,
  input wire logic pdo_valid_out,
  input wire logic sdo_reply_valid_out,
  input wire logic [10:0] sdo_reply_id_out,
  input wire logic sync_out,
  input wire logic [10:0] tpdo1_id_out,
  input wire logic [10:0] tpdo2_id_out,
  input wire logic [10:0] emcy_id_out
);
  localparam int PDO_WAIT = 3 * SLICE_CYCLES + 1;
  localparam int SDO_WAIT = 5 * SLICE_CYCLES;
  int gap;
  logic seen;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // Cycles since the last slice tick; the first tick only arms the check
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      gap <= 0;
      seen <= 1'b0;
    end else begin
      gap <= slice_tick_out ? 0 : gap + 1;
      seen <= seen | slice_tick_out;
    end
  end
  a_slice_period: assert property (seen |-> slice_tick_out == (gap == SLICE_CYCLES - 1))
    else $error("slice spacing wrong");
  a_pdo_on_slice: assert property (pdo_valid_out |-> slice_tick_out)
    else $error("process data off slice");
  a_slot_on_slice: assert property ((sdo_reply_valid_out || sync_out) |-> slice_tick_out)
    else $error("slot message off slice");
  // A reply answers the slice before it, so a sync there means two messages in one slice
  a_one_slot_msg: assert property (sync_out |-> ##SLICE_CYCLES !sdo_reply_valid_out)
    else $error("two slot messages in one slice");
  a_pdo_latency: assert property (
    rx_valid_in && bus_enable_out && (rx_id_in == tpdo1_id_out + 11'h080
    || rx_id_in == tpdo2_id_out + 11'h080) |-> ##[1:PDO_WAIT] pdo_valid_out)
    else $error("process data late");
  a_sdo_latency: assert property (
    rx_valid_in && bus_enable_out && rx_id_in == tpdo1_id_out + 11'h480
    |-> ##[1:SDO_WAIT] sdo_reply_valid_out)
    else $error("service reply late");
  a_reply_id: assert property (sdo_reply_valid_out |-> sdo_reply_id_out == tpdo1_id_out + 11'h400)
    else $error("reply id wrong");
  a_ids_follow: assert property (tpdo2_id_out == tpdo1_id_out + 11'h100 && emcy_id_out == tpdo1_id_out - 11'h100)
    else $error("ids disagree");
  a_bit_idle: assert property (!bus_enable_out && !$past(bus_enable_out) |-> !bit_tick_out)
    else $error("bit tick while inactive");
  a_read_zero: assert property (!$past(rd_in) |-> rd_data_out == 32'h0)
    else $error("read data outside its cycle");
  c_pdo: cover property (pdo_valid_out);
  c_sdo: cover property (sdo_reply_valid_out);
  c_sync: cover property (sync_out);
endmodule : can_sched_checker

bind can_message_scheduler can_sched_checker #(.SLICE_CYCLES(SLICE_CYCLES)) chk (
  .clock_in, .rst_in, .rd_in, .rd_data_out, .rx_valid_in, .rx_id_in, .bus_enable_out,
  .bit_tick_out, .slice_tick_out, .pdo_valid_out, .sdo_reply_valid_out, .sdo_reply_id_out,
  .sync_out, .tpdo1_id_out, .tpdo2_id_out, .emcy_id_out);

// [tb/can_master_model.sv]
`timescale 1ns/1ps
// ************************************************************
// Bus master stand-in
// ************************************************************
module can_master_model import can_sched_pkg::*; #(
  parameter int PDO_GAP = 50
) (
  input wire logic clock_in,
  output logic rx_valid_out,
  output logic [10:0] rx_id_out,
  output logic [31:0] rx_data_out,
  output logic rx_complex_out
);
  time last_pdo = 0;
  // Idle frame lines
  initial begin
    rx_valid_out = 1'b0;
    rx_id_out = 11'h7FF;
    rx_data_out = 32'h0;
    rx_complex_out = 1'b0;
  end
  // One frame per call, to whatever id the caller gives
  task automatic send(input logic [10:0] id, input logic [31:0] data, input logic cx);
    logic pdo;
    pdo = (id[10:7] == 4'h4) || (id[10:7] == 4'h6);
    while (pdo && $time < last_pdo + PDO_GAP * 10) @(posedge clock_in);
    @(posedge clock_in);
    rx_valid_out <= 1'b1;
    rx_id_out <= id;
    rx_data_out <= data;
    rx_complex_out <= cx;
    @(posedge clock_in);
    if (pdo) last_pdo = $time;
    rx_valid_out <= 1'b0;
    // Released fields never keep a stale copy
    rx_id_out <= ~id;
    rx_data_out <= ~data;
    rx_complex_out <= ~cx;
  endtask : send
endmodule : can_master_model

// [tb/tb_can_message_scheduler.sv]
`timescale 1ns/1ps
`include "can_sched_params.svh"
// ************************************************************
// Scheduler bench
// ************************************************************
module tb_can_message_scheduler import can_sched_pkg::*;;
  localparam int SLICE = 20;
  logic clock_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wr_data_in = 32'h0;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [3:0] node_offset_jumper_inputs_in = 4'h3;
  logic rx_valid_in, rx_complex_in, bus_enable_out, bit_tick_out, slice_tick_out;
  logic pdo_valid_out, pdo_channel_out, sdo_reply_valid_out, sync_out;
  logic [10:0] rx_id_in, sdo_reply_id_out, tpdo1_id_out, tpdo2_id_out, emcy_id_out;
  logic [31:0] rx_data_in, rd_data_out, pdo_data_out, sdo_reply_data_out, rd_val;
  int failures = 0;
  int checked = 0;
  int cyc, sl;
  // Free-running 100 MHz clock
  always #5 clock_in = ~clock_in;
  can_message_scheduler #(.SLICE_CYCLES(SLICE)) dut (.clock_in, .rst_in, .addr_in, .wr_data_in,
    .wr_in, .rd_in, .rd_data_out, .node_offset_jumper_inputs_in, .rx_valid_in, .rx_id_in,
    .rx_data_in, .rx_complex_in, .bus_enable_out, .bit_tick_out, .slice_tick_out,
    .pdo_valid_out, .pdo_channel_out, .pdo_data_out, .sdo_reply_valid_out, .sdo_reply_id_out,
    .sdo_reply_data_out, .sync_out, .tpdo1_id_out, .tpdo2_id_out, .emcy_id_out);
  can_master_model master (.clock_in, .rx_valid_out(rx_valid_in), .rx_id_out(rx_id_in),
    .rx_data_out(rx_data_in), .rx_complex_out(rx_complex_in));
  task automatic report_and_stop;
    if (failures == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t: got %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge clock_in);
    wr_in <= 1'b0;
  endtask : reg_wr
  // Read data is only looked at in the single cycle after the strobe
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clock_in);
    rd_in <= 1'b0;
    #1;
    d = rd_data_out;
  endtask : reg_rd
  // Bounded wait: 0 pdo, 1 reply, 2 sync, 3 slice tick, 4 bit tick
  task automatic wait_ev(input int sel, output int n, output int s);
    logic [4:0] ev;
    n = 0;
    s = 0;
    do begin
      @(posedge clock_in);
      #1;
      n++;
      ev = {bit_tick_out, slice_tick_out, sync_out, sdo_reply_valid_out, pdo_valid_out};
      if (slice_tick_out === 1'b1) s++;
      if (n > 1000) begin
        failures++;
        report_and_stop();
      end
    end while (ev[sel] !== 1'b1);
  endtask : wait_ev
  task automatic s_reset;
    reg_rd(`REG_CONFIG, rd_val);
    check(rd_val, 32'h0000_0001);
    reg_wr(`REG_STATUS, 32'h0000_007F);
    reg_rd(`REG_STATUS, rd_val);
    check(rd_val, 32'h0000_0001);
    reg_rd(8'h0C, rd_val);
    check(rd_val, 32'h0);
    check(32'(tpdo1_id_out), 32'h0000_0181);
  endtask : s_reset
  // Jumpers count only at activation; later changes wait for the next one
  task automatic s_node;
    reg_wr(`REG_CONFIG, 32'h0000_0485);
    repeat (3) @(posedge clock_in);
    check(32'(bus_enable_out), 32'h1);
    check(32'(tpdo2_id_out), 32'h0000_0288);
    node_offset_jumper_inputs_in <= 4'h9;
    reg_rd(`REG_STATUS, rd_val);
    check(rd_val, 32'h0000_0008);
    reg_wr(`REG_CONFIG, 32'h0000_0085);
    repeat (3) @(posedge clock_in);
    check(32'(bus_enable_out), 32'h0);
    reg_wr(`REG_CONFIG, 32'h0000_0485);
    // Capture, then node, then ids each take one more edge
    repeat (3) @(posedge clock_in);
    reg_rd(`REG_STATUS, rd_val);
    check(rd_val, 32'h0000_000E);
    check(32'(tpdo1_id_out), 32'h0000_018E);
  endtask : s_node
  task automatic s_pdo(input logic [10:0] id, input logic cx, input logic [31:0] d);
    wait_ev(3, cyc, sl);
    master.send(id, d, cx);
    wait_ev(0, cyc, sl);
    check(32'(sl), cx ? 32'h2 : 32'h1);
    check(32'(cyc <= 3 * SLICE + 1), 32'h1);
    check(32'(pdo_channel_out), 32'(id[8]));
    check(pdo_data_out, d);
  endtask : s_pdo
  // A sync arriving while the slot is busy is lost and counted
  task automatic s_sdo;
    wait_ev(3, cyc, sl);
    master.send(11'h60E, 32'hA5A5_1234, 1'b0);
    master.send(11'h080, 32'h0, 1'b0);
    wait_ev(1, cyc, sl);
    // Taken at the first tick, answered at the second
    check(32'(sl), 32'h2);
    check(32'(cyc <= 5 * SLICE), 32'h1);
    check(32'(sdo_reply_id_out), 32'h0000_058E);
    check(sdo_reply_data_out, 32'hA5A5_1234);
    reg_rd(`REG_DROPS, rd_val);
    check(rd_val, 32'h1);
    reg_wr(`REG_DROPS, 32'h0);
    reg_rd(`REG_DROPS, rd_val);
    check(rd_val, 32'h0);
    wait_ev(3, cyc, sl);
    master.send(11'h080, 32'h0, 1'b0);
    wait_ev(2, cyc, sl);
    check(32'(sl), 32'h1);
  endtask : s_sdo
  // The first gaps after a rate change may be partial, so the third is judged
  // Unused code 3 must fall back to the slowest rate
  task automatic s_rate;
    for (int r = 0; r < 4; r++) begin
      reg_wr(`REG_CONFIG, 32'h0000_0485 | (r << 8));
      repeat (3) wait_ev(4, cyc, sl);
      check(32'(cyc), 32'(`BIT_CYCLES_125 >> ((r == 3) ? 0 : r)));
    end
  endtask : s_rate
  task automatic s_inactive;
    int n;
    n = 0;
    reg_wr(`REG_CONFIG, 32'h0000_0085);
    master.send(11'h20E, 32'h0BAD_0BAD, 1'b0);
    repeat (4 * SLICE) begin
      @(posedge clock_in);
      #1;
      if (pdo_valid_out !== 1'b0 || bit_tick_out !== 1'b0) n++;
    end
    check(32'(n), 32'h0);
  endtask : s_inactive
  // Main sequence
  initial begin
    repeat (6) @(posedge clock_in);
    rst_in <= 1'b0;
    s_reset();
    s_node();
    s_pdo(11'h20E, 1'b0, 32'h1234_5678);
    s_sdo();
    s_rate();
    s_pdo(11'h30E, 1'b1, 32'hCAFE_0042);
    s_inactive();
    report_and_stop();
  end
endmodule : tb_can_message_scheduler
